// ==== pkg/bsd_pkg.sv ====
package bsd_pkg;

    // clock and timing
    localparam int CLK_NS           = 20;
    localparam int EXEC_NS          = 100;
    localparam int EXEC_CYCLES      = (EXEC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_SEQ_NS     = 2000;
    localparam int RESET_SEQ_CYCLES = (RESET_SEQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_CNT_W       = 8;

    // array geometry
    localparam int COLS             = 80;
    localparam int LINES            = 32;
    localparam int LINE_W           = 5;
    localparam int COL_W            = 7;
    localparam int PAGE_W           = 2;
    localparam int BIT_SEL_W        = 3;

    // column and line addressing
    localparam logic [COL_W-1:0]  COL_LIMIT   = 7'h50;
    localparam logic [COL_W-1:0]  COL_ONE     = 7'h01;
    localparam logic [COL_W-1:0]  COL_RESET   = 7'h00;
    localparam logic [PAGE_W-1:0] PAGE_RESET  = 2'h3;
    localparam logic [LINE_W-1:0] START_RESET = 5'h00;
    localparam logic [LINE_W-1:0] LINE_ONE    = 5'h01;

    // instruction codes
    localparam logic [7:0] INS_COL_MASK   = 8'h80;
    localparam logic [7:0] INS_COL_CODE   = 8'h00;
    localparam logic [7:0] INS_START_MASK = 8'he0;
    localparam logic [7:0] INS_START_CODE = 8'hc0;
    localparam logic [7:0] INS_PAGE_MASK  = 8'hfc;
    localparam logic [7:0] INS_PAGE_CODE  = 8'hb8;
    localparam logic [7:0] INS_RESET      = 8'he2;

    // status byte layout
    localparam int STAT_BUSY_BIT  = 7;
    localparam int STAT_RESET_BIT = 4;

    // column drive level codes
    localparam logic [1:0] LVL_TOP       = 2'h0;
    localparam logic [1:0] LVL_UPPER_MID = 2'h1;
    localparam logic [1:0] LVL_LOWER_MID = 2'h2;
    localparam logic [1:0] LVL_GROUND    = 2'h3;

    typedef enum logic {
        BSD_MODE_68 = 1'b0,
        BSD_MODE_80 = 1'b1
    } bsd_mode_t;

    typedef enum logic [1:0] {
        BSD_ST_READY = 2'b00,
        BSD_ST_RESET = 2'b01,
        BSD_ST_EXEC  = 2'b11
    } bsd_state_t;

endpackage : bsd_pkg

// ==== rtl/bsd_strobe_dec.sv ====
`timescale 1ns/100ps

module bsd_strobe_dec
    import bsd_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      nrst,
    input  wire bsd_mode_t mode,
    input  wire logic      cs_n,
    input  wire logic      e_rd,
    input  wire logic      rw_wr,
    output logic           rd_drive,
    output logic           rd_done,
    output logic           wr_done
);

    logic cs_n_q;
    logic e_rd_q;
    logic rw_wr_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_n_q  <= 1'b1;
            e_rd_q  <= 1'b0;
            rw_wr_q <= 1'b1;
        end else begin
            cs_n_q  <= cs_n;
            e_rd_q  <= e_rd;
            rw_wr_q <= rw_wr;
        end
    end

    wire drive_68 = !cs_n && e_rd && rw_wr;
    wire end_68   = !cs_n_q && e_rd_q && !e_rd;
    wire drive_80 = !cs_n && !e_rd;
    wire rd_80    = !cs_n_q && !e_rd_q && e_rd;
    wire wr_80    = !cs_n_q && !rw_wr_q && rw_wr;

    assign rd_drive = (mode == BSD_MODE_68) ? drive_68 : drive_80;
    assign rd_done  = (mode == BSD_MODE_68) ? (end_68 && rw_wr_q) : rd_80;
    assign wr_done  = (mode == BSD_MODE_68) ? (end_68 && !rw_wr_q) : wr_80;

endmodule : bsd_strobe_dec

// ==== rtl/bsd_col_level.sv ====
`timescale 1ns/100ps

module bsd_col_level
    import bsd_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  frame_alternation,
    input  wire logic [COLS-1:0]       pixel,
    output logic      [COLS-1:0][1:0]  seg_level
);

    for (genvar c = 0; c < COLS; c++) begin : g_col
        wire [1:0] lvl_d = frame_alternation ?
                           (pixel[c] ? LVL_TOP : LVL_UPPER_MID) :
                           (pixel[c] ? LVL_GROUND : LVL_LOWER_MID);
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                seg_level[c] <= LVL_LOWER_MID;
            end else begin
                seg_level[c] <= lvl_d;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    level_map_a: assert property (
        1'b1 |=> seg_level[0] == ($past(frame_alternation) ?
            ($past(pixel[0]) ? LVL_TOP : LVL_UPPER_MID) :
            ($past(pixel[0]) ? LVL_GROUND : LVL_LOWER_MID)))
        else $error("column level does not match frame and pixel");

endmodule : bsd_col_level

// ==== rtl/bsd_host_port.sv ====
`timescale 1ns/100ps

// Behaviour
// - bus cycles honoured only with chip select low
// - line strobe latches one display line
// - 68 mode enable strobe active high
// - 68 mode direction high reads, low writes
// - 80 mode read low drives the bus
// - 80 mode write taken at rising edge
// - select high is data, low instruction
// - 8-bit tri-state bus, released unless reading
// - column level from frame and pixel
// - reset sequence starts on reset pin edge
// - reset pin level selects host interface
// - busy refuses everything but status read; a data read still returns the RAM byte, column held
// - busy flag on data bit seven
// - start line register, five bits, loadable
// - line counter preset on frame change
// - line counter counts on strobe rise
// - seven bit presettable column counter
// - column counts per data access, stops 50H
// - page address untouched by column counting
// - reset clears column, page three, line zero; reset instruction E2 leaves the column
// - busy also during reset sequence
module bsd_host_port
    import bsd_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 cs_n,
    input  wire logic                 cmd_data_select,
    input  wire logic                 e_rd,
    input  wire logic                 rw_wr,
    input  wire logic [7:0]           data_in,
    output logic      [7:0]           data_out,
    output logic                      data_oe_n,
    input  wire logic                 reset_pin,
    input  wire logic                 line_latch_strobe,
    input  wire logic                 frame_alternation,
    output logic      [COLS-1:0][1:0] seg_level
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    bsd_mode_t               mode_q;
    bsd_state_t              state_q;
    logic [BUSY_CNT_W-1:0]   busy_cnt_q;
    logic [LINE_W-1:0]       start_q;
    logic [LINE_W-1:0]       line_cnt_q;
    logic [COL_W-1:0]        col_q;
    logic [PAGE_W-1:0]       page_q;
    logic [7:0]              wr_data_q;
    logic                    a0_q;
    logic                    pin_q;
    logic                    pin_valid_q;
    logic                    ll_q;
    logic                    fr_q;
    logic [COLS-1:0]         latch_q;
    logic [7:0]              rd_data_q;
    logic [COLS-1:0]         lines_q [LINES];

    logic                    rd_drive;
    logic                    rd_done;
    logic                    wr_done;
    logic [7:0]              ram_byte;

    ////////////////////////////////////////////////////////////////////////////
    // host strobes

    bsd_strobe_dec u_strobe (
        .clk      (clk),
        .nrst     (nrst),
        .mode     (mode_q),
        .cs_n     (cs_n),
        .e_rd     (e_rd),
        .rw_wr    (rw_wr),
        .rd_drive (rd_drive),
        .rd_done  (rd_done),
        .wr_done  (wr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode

    wire ready      = (state_q == BSD_ST_READY);
    wire busy_flag  = !ready;
    wire wr_take    = wr_done && ready;
    wire data_wr    = wr_take && a0_q;
    wire ins_wr     = wr_take && !a0_q;
    wire data_rd    = rd_done && a0_q && ready;
    wire col_ok     = (col_q < COL_LIMIT);
    wire is_col     = ((wr_data_q & INS_COL_MASK) == INS_COL_CODE);
    wire is_start   = ((wr_data_q & INS_START_MASK) == INS_START_CODE);
    wire is_page    = ((wr_data_q & INS_PAGE_MASK) == INS_PAGE_CODE);
    wire is_reset   = (wr_data_q == INS_RESET);
    wire pin_edge   = pin_valid_q && (reset_pin != pin_q);
    wire ll_rise    = line_latch_strobe && !ll_q;
    wire fr_change  = (frame_alternation != fr_q);
    wire [COLS-1:0] row_sel = lines_q[line_cnt_q];

    wire [7:0] status_byte = (8'(busy_flag) << STAT_BUSY_BIT)
                           | (8'(state_q == BSD_ST_RESET) << STAT_RESET_BIT);

    ////////////////////////////////////////////////////////////////////////////
    // sampled inputs

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_data_q   <= 8'h00;
            a0_q        <= 1'b0;
            pin_q       <= 1'b0;
            pin_valid_q <= 1'b0;
            ll_q        <= 1'b0;
            fr_q        <= 1'b0;
        end else begin
            wr_data_q   <= data_in;
            a0_q        <= cmd_data_select;
            pin_q       <= reset_pin;
            pin_valid_q <= 1'b1;
            ll_q        <= line_latch_strobe;
            fr_q        <= frame_alternation;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // busy and reset sequence

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q    <= BSD_ST_READY;
            busy_cnt_q <= '0;
            mode_q     <= BSD_MODE_68;
        end else begin
            case (state_q)
                BSD_ST_READY: begin
                    if (pin_edge) begin
                        state_q    <= BSD_ST_RESET;
                        busy_cnt_q <= BUSY_CNT_W'(RESET_SEQ_CYCLES - 1);
                    end else if (wr_take) begin
                        state_q    <= BSD_ST_EXEC;
                        busy_cnt_q <= BUSY_CNT_W'(EXEC_CYCLES - 1);
                    end
                end
                BSD_ST_EXEC: begin
                    if (pin_edge) begin
                        state_q    <= BSD_ST_RESET;
                        busy_cnt_q <= BUSY_CNT_W'(RESET_SEQ_CYCLES - 1);
                    end else if (busy_cnt_q == '0) begin
                        state_q <= BSD_ST_READY;
                    end else begin
                        busy_cnt_q <= busy_cnt_q - 1'b1;
                    end
                end
                BSD_ST_RESET: begin
                    if (pin_edge) begin
                        busy_cnt_q <= BUSY_CNT_W'(RESET_SEQ_CYCLES - 1);
                    end else if (busy_cnt_q == '0) begin
                        state_q <= BSD_ST_READY;
                        mode_q  <= reset_pin ? BSD_MODE_68 : BSD_MODE_80;
                    end else begin
                        busy_cnt_q <= busy_cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= BSD_ST_READY;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address registers

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_q <= START_RESET;
            col_q   <= COL_RESET;
            page_q  <= PAGE_RESET;
        end else if (pin_edge) begin
            start_q <= START_RESET;
            col_q   <= COL_RESET;
            page_q  <= PAGE_RESET;
        end else if (ins_wr) begin
            if (is_reset) begin
                start_q <= START_RESET;
                page_q  <= PAGE_RESET;
            end else if (is_start) begin
                start_q <= wr_data_q[LINE_W-1:0];
            end else if (is_page) begin
                page_q <= wr_data_q[PAGE_W-1:0];
            end else if (is_col) begin
                col_q <= wr_data_q[COL_W-1:0];
            end
        end else if ((data_wr || data_rd) && col_ok) begin
            // count, locked at limit; page kept
            col_q <= col_q + COL_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // display array

    always_ff @(posedge clk) begin
        if (data_wr && col_ok) begin
            for (int k = 0; k < 8; k++) begin
                lines_q[{page_q, BIT_SEL_W'(k)}][col_q] <= wr_data_q[k];
            end
        end
    end

    for (genvar k = 0; k < 8; k++) begin : g_rd
        assign ram_byte[k] = col_ok && lines_q[{page_q, BIT_SEL_W'(k)}][col_q];
    end

    ////////////////////////////////////////////////////////////////////////////
    // line counter and latch

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            line_cnt_q <= START_RESET;
            latch_q    <= '0;
        end else begin
            if (fr_change) begin
                line_cnt_q <= start_q;
            end else if (ll_rise) begin
                line_cnt_q <= line_cnt_q + LINE_ONE;
            end
            if (ll_rise) begin
                latch_q <= row_sel;
            end
        end
    end

    bsd_col_level u_level (
        .clk               (clk),
        .nrst              (nrst),
        .frame_alternation (frame_alternation),
        .pixel             (latch_q),
        .seg_level         (seg_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read path

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= 8'h00;
        end else begin
            // status carries busy on bit seven
            rd_data_q <= cmd_data_select ? ram_byte : status_byte;
        end
    end

    // bus released unless read in progress
    assign data_out  = rd_data_q;
    assign data_oe_n = !rd_drive;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    cs_gate_a: assert property (
        cs_n |-> data_oe_n)
        else $error("bus driven without chip select");

    read_68_a: assert property (
        (mode_q == BSD_MODE_68) && !cs_n && e_rd |-> (data_oe_n == !rw_wr))
        else $error("68 mode read drive wrong");

    read_80_a: assert property (
        (mode_q == BSD_MODE_80) && !cs_n |-> (data_oe_n == e_rd))
        else $error("80 mode read drive wrong");

    start_load_a: assert property (
        ins_wr && is_start && !pin_edge |=> start_q == $past(wr_data_q[LINE_W-1:0]))
        else $error("start line not loaded");

    busy_refuse_a: assert property (
        wr_done && busy_flag && !pin_edge |=> $stable(col_q) && $stable(start_q))
        else $error("write honoured while busy");

    status_bit_a: assert property (
        !cmd_data_select |=> rd_data_q[STAT_BUSY_BIT] == $past(busy_flag))
        else $error("busy flag not on bit seven");

    line_preset_a: assert property (
        fr_change |=> line_cnt_q == $past(start_q))
        else $error("line counter not preset on frame change");

    line_count_a: assert property (
        ll_rise && !fr_change |=> line_cnt_q == $past(line_cnt_q) + LINE_ONE)
        else $error("line counter did not advance");

    row_latch_a: assert property (
        ll_rise |=> latch_q == $past(row_sel))
        else $error("display line not latched");

    col_step_a: assert property (
        data_wr && col_ok && !pin_edge |=> col_q == $past(col_q) + COL_ONE)
        else $error("column counter did not step");

    col_lock_a: assert property (
        (col_q == COL_LIMIT) && !ins_wr && !pin_edge |=> col_q == COL_LIMIT)
        else $error("column counter passed its limit");

    page_hold_a: assert property (
        (data_wr || data_rd) && !pin_edge |=> $stable(page_q))
        else $error("page changed by column counting");

    reset_init_a: assert property (
        pin_edge |=> col_q == COL_RESET && page_q == PAGE_RESET && start_q == START_RESET)
        else $error("reset values not applied");

    reset_busy_a: assert property (
        pin_edge |=> (state_q == BSD_ST_RESET) [*8])
        else $error("not busy during reset sequence");

    mode_pick_a: assert property (
        state_q == BSD_ST_RESET && busy_cnt_q == '0 && !pin_edge
        |=> mode_q == ($past(reset_pin) ? BSD_MODE_68 : BSD_MODE_80))
        else $error("interface not selected from pin level");

    data_wr_c:    cover property (data_wr && col_ok);
    col_lock_c:   cover property (data_wr && (col_q == COL_LIMIT));
    mode_80_c:    cover property (mode_q == BSD_MODE_80 && wr_take);
    frame_line_c: cover property (fr_change ##[1:50] ll_rise);

endmodule : bsd_host_port

// ==== test/bsd_host_model.sv ====
`timescale 1ns/100ps

module bsd_host_model
    import bsd_pkg::*;
(
    input  wire logic       clk,
    input  wire bsd_mode_t  mode,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    output logic            cs_n,
    output logic            cmd_data_select,
    output logic            e_rd,
    output logic            rw_wr,
    output logic      [7:0] data_in
);
    logic       host_oe = 1'b0;
    logic [7:0] host_d  = 8'h00;
    logic [7:0] float_d = 8'h00;

    initial begin
        cs_n = 1'b1;
        cmd_data_select = 1'b0;
        e_rd = 1'b0;
        rw_wr = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // released bus shows a changing pattern, never the last value
    always @(posedge clk) float_d <= ~data_in;
    always @* begin
        if (!data_oe_n) data_in = data_out;
        else if (host_oe) data_in = host_d;
        else data_in = float_d;
    end

    ////////////////////////////////////////////////////////////////
    // decoded select, spaced cycles
    task automatic access(input logic sel, input logic rd, input logic cmd,
                          input logic [7:0] wd, input int idle,
                          output logic [7:0] rdata, output logic oe_seen);
        @(posedge clk);
        cs_n <= !sel;
        cmd_data_select <= cmd;
        e_rd <= (mode == BSD_MODE_68) ? 1'b1 : !rd;
        rw_wr <= rd;
        host_oe <= !rd;
        host_d <= wd;
        @(posedge clk);
        if (rd) @(posedge clk);
        rdata = data_in;
        oe_seen = data_oe_n;
        e_rd <= (mode == BSD_MODE_80);
        rw_wr <= 1'b1;
        @(posedge clk);
        cs_n <= 1'b1;
        host_oe <= 1'b0;
        repeat (idle) @(posedge clk);
    endtask : access
endmodule : bsd_host_model

// ==== test/test_bsd_host_port.sv ====
`timescale 1ns/100ps

module test_bsd_host_port
    import bsd_pkg::*;
;
    typedef struct packed {
        logic       sel;
        logic       rd;
        logic       cmd;
        logic [7:0] wd;
        logic [7:0] exp;
    } bsd_row_t;

    logic                 clk;
    logic                 nrst;
    logic                 reset_pin;
    logic                 line_latch_strobe;
    logic                 frame_alternation;
    bsd_mode_t            host_mode;
    logic                 cs_n;
    logic                 cmd_data_select;
    logic                 e_rd;
    logic                 rw_wr;
    logic [7:0]           data_in;
    logic [7:0]           data_out;
    logic                 data_oe_n;
    logic [COLS-1:0][1:0] seg_level;
    logic [7:0]           rdata;
    logic                 oe_seen;
    int                   err_count = 0;
    int                   n_compared = 0;

    bsd_row_t rows [0:24] = '{
        '{1'b1, 1'b0, 1'b1, 8'h5a, 8'h00}, '{1'b1, 1'b0, 1'b0, 8'hb8, 8'h00},
        '{1'b1, 1'b0, 1'b0, 8'h00, 8'h00}, '{1'b1, 1'b0, 1'b1, 8'ha5, 8'h00},
        '{1'b0, 1'b0, 1'b1, 8'hff, 8'h00}, '{1'b1, 1'b0, 1'b1, 8'h3c, 8'h00},
        '{1'b1, 1'b0, 1'b0, 8'h00, 8'h00}, '{1'b1, 1'b1, 1'b1, 8'h00, 8'ha5},
        '{1'b1, 1'b1, 1'b1, 8'h00, 8'h3c}, '{1'b1, 1'b0, 1'b0, 8'hbb, 8'h00},
        '{1'b1, 1'b0, 1'b0, 8'h00, 8'h00}, '{1'b1, 1'b1, 1'b1, 8'h00, 8'h5a},
        '{1'b1, 1'b0, 1'b0, 8'h4f, 8'h00}, '{1'b1, 1'b0, 1'b1, 8'h11, 8'h00},
        '{1'b1, 1'b0, 1'b1, 8'h22, 8'h00}, '{1'b1, 1'b0, 1'b0, 8'h4f, 8'h00},
        '{1'b1, 1'b1, 1'b1, 8'h00, 8'h11}, '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00},
        '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00}, '{1'b1, 1'b0, 1'b0, 8'h00, 8'h00},
        '{1'b1, 1'b1, 1'b1, 8'h00, 8'h5a}, '{1'b1, 1'b0, 1'b0, 8'hb8, 8'h00},
        '{1'b1, 1'b0, 1'b0, 8'h00, 8'h00}, '{1'b1, 1'b1, 1'b1, 8'h00, 8'ha5},
        '{1'b0, 1'b1, 1'b0, 8'h00, 8'h00}
    };

    bsd_host_port dut (
        .clk               (clk),
        .nrst              (nrst),
        .cs_n              (cs_n),
        .cmd_data_select   (cmd_data_select),
        .e_rd              (e_rd),
        .rw_wr             (rw_wr),
        .data_in           (data_in),
        .data_out          (data_out),
        .data_oe_n         (data_oe_n),
        .reset_pin         (reset_pin),
        .line_latch_strobe (line_latch_strobe),
        .frame_alternation (frame_alternation),
        .seg_level         (seg_level)
    );

    bsd_host_model host (
        .clk             (clk),
        .mode            (host_mode),
        .data_out        (data_out),
        .data_oe_n       (data_oe_n),
        .cs_n            (cs_n),
        .cmd_data_select (cmd_data_select),
        .e_rd            (e_rd),
        .rw_wr           (rw_wr),
        .data_in         (data_in)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic wait_ready();
        for (int i = 0; i < 30; i++) begin
            host.access(1'b1, 1'b1, 1'b0, 8'h00, 0, rdata, oe_seen);
            if (rdata[7] === 1'b0) return;
        end
        err_count++;
        stop_test();
    endtask : wait_ready

    // strobe from the row timing side
    task automatic line_step(input logic fr);
        @(posedge clk);
        frame_alternation <= fr;
        repeat (3) @(posedge clk);
        line_latch_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        line_latch_strobe <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : line_step

    ////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        reset_pin = 1'b1;
        line_latch_strobe = 1'b0;
        frame_alternation = 1'b0;
        host_mode = BSD_MODE_68;
        repeat (16) @(posedge clk);
        check(data_out, 8'h00);
        check({6'h00, seg_level[0]}, {6'h00, LVL_LOWER_MID});
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        // pulse ends high, keeps the 68 host
        reset_pin <= 1'b0;
        @(posedge clk);
        reset_pin <= 1'b1;
        host.access(1'b1, 1'b1, 1'b0, 8'h00, 0, rdata, oe_seen);
        check(rdata, 8'h90);
        wait_ready();
        foreach (rows[i]) begin
            host.access(rows[i].sel, rows[i].rd, rows[i].cmd, rows[i].wd, 6, rdata, oe_seen);
            if (!rows[i].sel)
                check({7'h00, oe_seen}, 8'h01);
            else if (rows[i].rd) begin
                check({7'h00, oe_seen}, 8'h00);
                check(rdata, rows[i].exp);
            end
        end
        // busy window right after an accepted write
        host.access(1'b1, 1'b0, 1'b0, 8'h01, 0, rdata, oe_seen);
        host.access(1'b1, 1'b1, 1'b0, 8'h00, 0, rdata, oe_seen);
        check(rdata, 8'h80);
        wait_ready();
        host.access(1'b1, 1'b0, 1'b0, 8'h01, 0, rdata, oe_seen);
        host.access(1'b1, 1'b0, 1'b0, 8'h00, 6, rdata, oe_seen);
        host.access(1'b1, 1'b1, 1'b1, 8'h00, 6, rdata, oe_seen);
        check(rdata, 8'h3c);
        // display path: lines 0 to 7 hold a5 at column 0 of page 0
        host.access(1'b1, 1'b0, 1'b0, 8'hc0, 6, rdata, oe_seen);
        line_step(1'b1);
        check({6'h00, seg_level[0]}, {6'h00, LVL_TOP});
        check({6'h00, seg_level[1]}, {6'h00, LVL_UPPER_MID});
        line_step(1'b1);
        check({6'h00, seg_level[0]}, {6'h00, LVL_UPPER_MID});
        host.access(1'b1, 1'b0, 1'b0, 8'hc2, 6, rdata, oe_seen);
        line_step(1'b0);
        check({6'h00, seg_level[0]}, {6'h00, LVL_GROUND});
        line_step(1'b0);
        check({6'h00, seg_level[0]}, {6'h00, LVL_LOWER_MID});
        // reset instruction: page three, start line zero
        host.access(1'b1, 1'b0, 1'b0, 8'he2, 6, rdata, oe_seen);
        host.access(1'b1, 1'b0, 1'b0, 8'h00, 6, rdata, oe_seen);
        host.access(1'b1, 1'b1, 1'b1, 8'h00, 6, rdata, oe_seen);
        check(rdata, 8'h5a);
        line_step(1'b1);
        check({6'h00, seg_level[1]}, {6'h00, LVL_UPPER_MID});
        // falling edge, low level picks the 80 host
        @(posedge clk);
        reset_pin <= 1'b0;
        repeat (110) @(posedge clk);
        host_mode = BSD_MODE_80;
        wait_ready();
        check(rdata, 8'h00);
        host.access(1'b1, 1'b0, 1'b0, 8'h05, 6, rdata, oe_seen);
        host.access(1'b1, 1'b0, 1'b1, 8'h6e, 6, rdata, oe_seen);
        host.access(1'b1, 1'b0, 1'b0, 8'h05, 6, rdata, oe_seen);
        host.access(1'b1, 1'b1, 1'b1, 8'h00, 6, rdata, oe_seen);
        check({7'h00, oe_seen}, 8'h00);
        check(rdata, 8'h6e);
        stop_test();
    end
endmodule : test_bsd_host_port
